// ===== hw/dmem_params.svh
`ifndef DMEM_PARAMS_SVH
`define DMEM_PARAMS_SVH

// ****************************************
// Data memory map (data address space)
// ****************************************
`define IDX_INDIRECT_PORT 8'h00
`define IDX_POINTER 8'h01
`define IDX_ACC 8'h05
`define IDX_PCL 8'h06
`define IDX_TBLP 8'h07
`define IDX_TABLE_HIGH_LATCH 8'h08
`define IDX_TBHP 8'h09
`define SFR_FIRST 8'h00
`define SFR_LAST 8'h3F
`define GPR_FIRST 8'h40
`define GPR_LAST 8'h7F
`define UNUSED_READ 8'h00
`define POINTER_BIT7_READ 1'b1
`define RESET_BYTE 8'h00
`define RESET_POINTER 7'h00

// ****************************************
// Bus map: word index of each register
// ****************************************
`define IDX_CMD 10'h080
`define IDX_STATUS 10'h081

// ****************************************
// Command register fields
// ****************************************
`define CMD_ADDR_LSB 0
`define CMD_BIT_LSB 8
`define CMD_OP_LSB 12
`define CMD_OP_NONE 3'h0
`define CMD_OP_SET 3'h1
`define CMD_OP_CLR 3'h2
`define CMD_OP_INC 3'h3
`define CMD_OP_DEC 3'h4
`define CMD_OP_TABLE 3'h5
`define STATUS_BUSY_BIT 0

// ****************************************
// Program memory and bus responses
// ****************************************
`define PM_WORD_W 14
`define PM_ADDR_W 10
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== hw/dmem_pkg.sv
package dmem_pkg;

  // Operations the access engine can perform
  typedef enum logic [2:0] {
    OP_NONE, OP_SET_BIT, OP_CLR_BIT, OP_INC, OP_DEC, OP_TABLE_READ
  } cmd_op_t;

  // Access engine states
  typedef enum logic [1:0] {
    ST_IDLE, ST_EXEC, ST_TAB_FETCH, ST_TAB_STORE
  } engine_state_t;

  // One write into data memory, before pointer resolution
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } mem_write_t;

  // Command held by the engine
  typedef struct packed {
    cmd_op_t op;
    logic [2:0] bit_sel;
    logic [7:0] addr;
  } engine_cmd_t;

endpackage : dmem_pkg

// ===== hw/data_memory_indirect_access.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dmem_params.svh"
// Notes on behaviour
// (RULE1) Every data memory location holds one 8-bit byte in volatile storage.
// (RULE2) Special function registers occupy data addresses 00H to 3FH.
// (RULE3) General purpose RAM occupies data addresses 40H to 7FH.
// (RULE4) Every general purpose RAM byte can be read and written.
// (RULE5) Bit set and bit clear change one chosen bit and leave the others alone.
// (RULE6) Unused special function addresses read as 00H.
// (RULE7) Registers sit at fixed addresses and read-only ones ignore writes.
// (RULE8) Accesses to the indirect port act on the location named by the pointer.
// (RULE9) The indirect port itself stores nothing, reads 00H and ignores writes.
// (RULE10) The port and pointer together reach only bank 0.
// (RULE11) The pointer is a real register that can be read, written, stepped up or down.
// (RULE12) Pointer bit 7 plays no part in addressing and always reads as 1.
// (RULE13) A table read puts the low byte in the target and the upper part in the latch.
// (RULE14) Latch bits above the program word width read as 0.
// (RULE15) A table read takes two cycles.
// (RULE16) The indirect target address is the low seven pointer bits.
module data_memory_indirect_access (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, low active
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [11:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [11:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [`PM_ADDR_W-1:0] pm_addr, // Program memory word address
  output logic pm_rd, // Program memory read strobe
  input wire logic [`PM_WORD_W-1:0] pm_data // Program word, cycle after pm_rd
);
  import dmem_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [6:0] ptr; // Pointer bits 6..0 only
  logic [7:0] acc, program_counter_low, tblp, table_high_latch, tbhp;
  logic [7:0] gpr [0:63]; // [RULE1] [RULE3]
  engine_state_t state;
  engine_cmd_t cmd;
  logic aw_held, w_held, aw_ok, w_lane0;
  logic [9:0] aw_idx;
  logic [14:0] w_bits;

  // ****************************************
  // Helper functions
  // ****************************************
  // Pointer redirection for the indirect port
  function automatic logic [7:0] resolve(input logic [7:0] a, input logic [6:0] p);
    resolve = (a == `IDX_INDIRECT_PORT) ? {1'b0, p} : a; // [RULE8] [RULE10] [RULE16]
  endfunction : resolve

  function automatic logic in_gpr(input logic [7:0] a);
    in_gpr = (a >= `GPR_FIRST) && (a <= `GPR_LAST); // [RULE3]
  endfunction : in_gpr

  // Read one data byte at a resolved address
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    if (in_gpr(a)) begin
      read_byte = gpr[a[5:0]]; // [RULE4]
    end else if (a == `IDX_POINTER) begin // [RULE2] [RULE7]
      read_byte = {`POINTER_BIT7_READ, ptr}; // [RULE12]
    end else if (a == `IDX_ACC) begin
      read_byte = acc;
    end else if (a == `IDX_PCL) begin
      read_byte = program_counter_low;
    end else if (a == `IDX_TBLP) begin
      read_byte = tblp;
    end else if (a == `IDX_TABLE_HIGH_LATCH) begin
      read_byte = table_high_latch;
    end else if (a == `IDX_TBHP) begin
      read_byte = tbhp;
    end else begin
      read_byte = `UNUSED_READ; // [RULE6] [RULE9]
    end
  endfunction : read_byte

  function automatic logic addr_is_mem(input logic [11:0] a);
    addr_is_mem = (a[11:9] == 3'h0) && (a[1:0] == 2'h0);
  endfunction : addr_is_mem

  function automatic logic addr_is_reg(input logic [11:0] a, input logic [9:0] idx);
    addr_is_reg = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction : addr_is_reg

  function automatic cmd_op_t to_op(input logic [2:0] code);
    case (code)
      `CMD_OP_SET: to_op = OP_SET_BIT;
      `CMD_OP_CLR: to_op = OP_CLR_BIT;
      `CMD_OP_INC: to_op = OP_INC;
      `CMD_OP_DEC: to_op = OP_DEC;
      `CMD_OP_TABLE: to_op = OP_TABLE_READ;
      default: to_op = OP_NONE;
    endcase
  endfunction : to_op

  // ****************************************
  // Decode and write-port selection
  // ****************************************
  logic axi_go, go_mem, go_cmd, go_status;
  logic [7:0] eng_eff, eng_old, eng_mask, eng_data, w_eff;
  logic [5:0] pm_high;
  cmd_op_t new_op;
  mem_write_t wport;
  assign axi_go = aw_held && w_held && !bvalid && (state == ST_IDLE);
  assign go_mem = axi_go && (aw_idx[9:7] == 3'h0) && aw_ok;
  assign go_cmd = axi_go && (aw_idx == `IDX_CMD) && aw_ok;
  assign go_status = axi_go && (aw_idx == `IDX_STATUS) && aw_ok;
  assign new_op = to_op(w_bits[`CMD_OP_LSB +: 3]);
  assign eng_eff = resolve(cmd.addr, ptr);
  always_comb eng_old = read_byte(eng_eff); // Process, so it follows the bytes it reads
  assign eng_mask = 8'h01 << cmd.bit_sel;
  assign eng_data = (cmd.op == OP_SET_BIT) ? (eng_old | eng_mask) : // [RULE5]
                    (cmd.op == OP_CLR_BIT) ? (eng_old & ~eng_mask) : // [RULE5]
                    (cmd.op == OP_INC) ? (eng_old + 8'h01) : // [RULE11]
                    (cmd.op == OP_DEC) ? (eng_old - 8'h01) : eng_old; // [RULE11]
  assign pm_high = pm_data[`PM_WORD_W-1:8];
  assign wport = go_mem ? {w_lane0, aw_idx[7:0], w_bits[7:0]} :
                 (state == ST_EXEC) ? {1'b1, cmd.addr, eng_data} :
                 {state == ST_TAB_STORE, cmd.addr, pm_data[7:0]}; // [RULE13]
  assign w_eff = resolve(wport.addr, ptr);

  // ****************************************
  // Data memory write
  // ****************************************
  // Applies one resolved write; read-only and unused slots drop it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= `RESET_POINTER;
      acc <= `RESET_BYTE;
      program_counter_low <= `RESET_BYTE;
      tblp <= `RESET_BYTE;
      table_high_latch <= `RESET_BYTE;
      tbhp <= `RESET_BYTE;
      for (int i = 0; i < 64; i++) begin
        gpr[i] <= `RESET_BYTE;
      end
    end else if (ce) begin
      if (wport.en && in_gpr(w_eff)) begin
        gpr[w_eff[5:0]] <= wport.data; // [RULE4]
      end else if (wport.en && w_eff == `IDX_POINTER) begin
        ptr <= wport.data[6:0]; // [RULE11] [RULE12]
      end else if (wport.en && w_eff == `IDX_ACC) begin
        acc <= wport.data;
      end else if (wport.en && w_eff == `IDX_PCL) begin
        program_counter_low <= wport.data;
      end else if (wport.en && w_eff == `IDX_TBLP) begin
        tblp <= wport.data;
      end else if (wport.en && w_eff == `IDX_TBHP) begin
        tbhp <= wport.data;
      end // Latch, port and unused slots ignore writes [RULE7] [RULE9]
      if (state == ST_TAB_STORE) begin
        table_high_latch <= {2'b00, pm_high}; // [RULE13] [RULE14]
      end
    end
  end

  // ****************************************
  // Access engine
  // ****************************************
  // Bit ops and steps take one cycle, table reads two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cmd <= '{op: OP_NONE, bit_sel: 3'h0, addr: 8'h00};
      pm_rd <= 1'b0;
      pm_addr <= '0;
    end else if (ce) begin
      pm_rd <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (go_cmd) begin
            cmd <= '{op: new_op, bit_sel: w_bits[`CMD_BIT_LSB +: 3],
                     addr: w_bits[`CMD_ADDR_LSB +: 8]};
            if (new_op == OP_TABLE_READ) begin
              state <= ST_TAB_FETCH; // [RULE15]
              pm_rd <= 1'b1;
              pm_addr <= {tbhp[1:0], tblp}; // [RULE13]
            end else if (new_op != OP_NONE) begin
              state <= ST_EXEC;
            end
          end
        end
        ST_EXEC: state <= ST_IDLE;
        ST_TAB_FETCH: state <= ST_TAB_STORE; // [RULE15]
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  // Address and data latch independently; response follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= '0;
      aw_ok <= 1'b0;
      w_bits <= '0;
      w_lane0 <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_idx <= awaddr[11:2];
        aw_ok <= (awaddr[1:0] == 2'h0);
        awready <= 1'b0;
      end else if (!aw_held && !axi_go) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_bits <= wdata[14:0];
        w_lane0 <= wstrb[0];
        wready <= 1'b0;
      end else if (!w_held && !axi_go) begin
        wready <= 1'b1;
      end
      if (axi_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (go_mem || go_cmd || go_status) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channels
  // ****************************************
  logic ar_go;
  logic [31:0] rd_word;
  logic rd_ok;
  assign ar_go = arvalid && arready;
  assign rd_ok = addr_is_mem(araddr) || addr_is_reg(araddr, `IDX_CMD) ||
                 addr_is_reg(araddr, `IDX_STATUS);
  // Read mux as a process, so it follows every byte the helper looks at
  always_comb rd_word = addr_is_mem(araddr) ?
                        {24'h000000, read_byte(resolve(araddr[9:2], ptr))} : // [RULE8]
                        addr_is_reg(araddr, `IDX_CMD) ?
                        {17'h00000, cmd.op, 1'b0, cmd.bit_sel, cmd.addr} :
                        addr_is_reg(araddr, `IDX_STATUS) ?
                        {31'h0, state != ST_IDLE} : 32'h00000000;

  // One read at a time, data registered at acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (ar_go) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [5:0] w_gidx, e_gidx;
  logic ar_ptr, ar_empty;
  assign w_gidx = w_eff[5:0];
  assign e_gidx = eng_eff[5:0];
  assign ar_ptr = ar_go && ce && addr_is_reg(araddr, {2'b00, `IDX_POINTER});
  assign ar_empty = ar_go && ce && addr_is_mem(araddr) && !in_gpr(araddr[9:2]) &&
                    (araddr[9:2] > `IDX_TBHP ||
                     (araddr[9:2] > `IDX_POINTER && araddr[9:2] < `IDX_ACC));
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tab_two_cycles;
    (state == ST_TAB_FETCH && ce) |=> (state == ST_TAB_STORE);
  endproperty
  a_tab_two_cycles: assert property (p_tab_two_cycles) else $error("table read not two cycles"); // [RULE15]
  property p_table_high_latch_zero;
    table_high_latch[7:6] == 2'b00;
  endproperty
  a_table_high_latch_zero: assert property (p_table_high_latch_zero) else $error("latch upper bits nonzero"); // [RULE14]
  property p_table_high_latch_load;
    (state == ST_TAB_STORE && ce) |=> (table_high_latch == {2'b00, $past(pm_high)});
  endproperty
  a_table_high_latch_load: assert property (p_table_high_latch_load) else $error("latch not loaded"); // [RULE13]
  property p_ptr_bit7;
    ar_ptr |=> rdata[7];
  endproperty
  a_ptr_bit7: assert property (p_ptr_bit7) else $error("pointer bit 7 not 1"); // [RULE12]
  property p_unused_zero;
    ar_empty |=> (rdata[7:0] == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused slot not 00H"); // [RULE6]
  property p_gpr_write;
    (wport.en && in_gpr(w_eff) && ce) |=> (gpr[$past(w_gidx)] == $past(wport.data));
  endproperty
  a_gpr_write: assert property (p_gpr_write) else $error("RAM write lost"); // [RULE4]
  property p_table_high_latch_ro;
    (wport.en && w_eff == `IDX_TABLE_HIGH_LATCH && state != ST_TAB_STORE && ce) |=> $stable(table_high_latch);
  endproperty
  a_table_high_latch_ro: assert property (p_table_high_latch_ro) else $error("read-only latch written"); // [RULE7]
  property p_set_bit;
    (state == ST_EXEC && cmd.op == OP_SET_BIT && in_gpr(eng_eff) && ce) |=>
      (gpr[$past(e_gidx)] == ($past(eng_old) | $past(eng_mask)));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set disturbed byte"); // [RULE5]
  property p_ptr_inc;
    (state == ST_EXEC && cmd.op == OP_INC && eng_eff == `IDX_POINTER && ce) |=>
      (ptr == $past(ptr) + 7'h01);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer step wrong"); // [RULE11]

endmodule : data_memory_indirect_access

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`include "dmem_params.svh"
module tb_top;
  import dmem_pkg::*;

  // ****************************************
  // Signals and bench state
  // ****************************************
  typedef struct packed {logic [11:0] addr; logic [31:0] data; logic [1:0] resp;} exp_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pm_rd;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [`PM_ADDR_W-1:0] pm_addr, exp_pm;
  logic [`PM_WORD_W-1:0] pm_data = '0;
  logic pm_hold = 1'b0;
  logic pm_rd_prev = 1'b0;
  logic [31:0] seed = 32'h00000030;
  logic [31:0] last_cmd;
  exp_t exp_w[$];
  exp_t exp_r[$];
  exp_t got_w, got_r;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] gpr[5] = '{8'h40, 8'h41, 8'h5A, 8'h7E, 8'h7F};
  logic [7:0] unused[4] = '{8'h02, 8'h03, 8'h04, 8'h3F};
  logic [31:0] vals[5];

  // Clock
  always #5 aclk = ~aclk;

  data_memory_indirect_access u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));

  // ****************************************
  // Helpers and bus tasks
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [11:0] ba(input logic [7:0] d);
    return {2'b00, d, 2'b00};
  endfunction : ba

  function automatic logic [13:0] pm_word(input logic [9:0] a);
    return {a[5:0] + 6'h2B, a[7:0] ^ 8'h96};
  endfunction : pm_word

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] r = `RESP_OKAY);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    exp_w.push_back(exp_t'{a, 32'h00000000, r});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = `RESP_OKAY);
    exp_r.push_back(exp_t'{a, d, r});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
  endtask : rd

  task automatic cmd(input logic [2:0] op, input logic [2:0] bs, input logic [7:0] a);
    last_cmd = {17'h00000, op, 1'b0, bs, a};
    wr({`IDX_CMD, 2'b00}, last_cmd);
    repeat (2) @(posedge aclk);
    rd({`IDX_STATUS, 2'b00}, 32'h00000000);
  endtask : cmd

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Response monitor: oldest note against each answer
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      got_w = exp_w.pop_front();
      check($sformatf("bresp at %h", got_w.addr), {30'h0, bresp}, {30'h0, got_w.resp});
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      got_r = exp_r.pop_front();
      check($sformatf("rdata at %h", got_r.addr), rdata, got_r.data);
      check($sformatf("rresp at %h", got_r.addr), {30'h0, rresp}, {30'h0, got_r.resp});
    end
  end

  // Program memory: word valid for two cycles from the cycle after the request, scrambled otherwise
  always @(posedge aclk) begin
    pm_rd_prev <= pm_rd;
    if (pm_rd === 1'b1) begin
      check("pm_addr", {22'h0, pm_addr}, {22'h0, exp_pm});
      check("pm_rd pulse", {31'h0, pm_rd_prev}, 32'h0);
      pm_data <= pm_word(pm_addr);
      pm_hold <= 1'b1;
    end else if (pm_hold) begin
      pm_hold <= 1'b0;
    end else begin
      pm_data <= ~pm_data;
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    $display("BAD watchdog expected completion seen hang");
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {ce, bready, rready} <= 3'b111;
    {awvalid, wvalid, arvalid} <= 3'b000;
    {awaddr, araddr, wdata, wstrb} <= '0;
    exp_pm = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(ba(8'h40), 32'h00000000);
    rd(ba(`IDX_POINTER), 32'h00000080);
    foreach (gpr[i]) begin
      vals[i] = xs();
      wr(ba(gpr[i]), vals[i]);
    end
    foreach (gpr[i]) rd(ba(gpr[i]), {24'h0, vals[i][7:0]});
    wr(ba(8'h41), 32'h000000FF, 4'hE);
    rd(ba(8'h41), {24'h0, vals[1][7:0]});
    foreach (unused[i]) begin
      wr(ba(unused[i]), 32'h000000FF);
      rd(ba(unused[i]), 32'h00000000);
    end
    wr(ba(`IDX_TABLE_HIGH_LATCH), 32'h0000005A);
    rd(ba(`IDX_TABLE_HIGH_LATCH), 32'h00000000);
    // Indirect access through the pointer
    wr(ba(`IDX_POINTER), 32'h00000045);
    rd(ba(`IDX_POINTER), 32'h000000C5);
    wr(ba(`IDX_INDIRECT_PORT), 32'h000000A5);
    rd(ba(8'h45), 32'h000000A5);
    rd(ba(`IDX_INDIRECT_PORT), 32'h000000A5);
    wr(ba(`IDX_POINTER), 32'h000000C6);
    wr(ba(`IDX_INDIRECT_PORT), 32'h0000003C);
    rd(ba(8'h46), 32'h0000003C);
    rd(ba(`IDX_POINTER), 32'h000000C6);
    wr(ba(`IDX_POINTER), 32'h00000000);
    rd(ba(`IDX_INDIRECT_PORT), 32'h00000000);
    wr(ba(`IDX_INDIRECT_PORT), 32'h00000077);
    rd(ba(`IDX_INDIRECT_PORT), 32'h00000000);
    // Bit operations, no-op codes, pointer stepping
    wr(ba(8'h50), 32'h000000A5);
    cmd(`CMD_OP_SET, 3'h1, 8'h50);
    rd(ba(8'h50), 32'h000000A7);
    cmd(`CMD_OP_CLR, 3'h7, 8'h50);
    rd(ba(8'h50), 32'h00000027);
    for (int op = 6; op < 9; op++) cmd(3'(op), 3'h0, 8'h50);
    rd(ba(8'h50), 32'h00000027);
    wr(ba(`IDX_POINTER), 32'h00000010);
    cmd(`CMD_OP_INC, 3'h0, `IDX_POINTER);
    rd(ba(`IDX_POINTER), 32'h00000091);
    repeat (2) cmd(`CMD_OP_DEC, 3'h0, `IDX_POINTER);
    rd(ba(`IDX_POINTER), 32'h0000008F);
    // Table reads from two consecutive program words
    wr(ba(`IDX_TBLP), 32'h00000006);
    wr(ba(`IDX_TBHP), 32'h00000003);
    exp_pm = 10'h306;
    cmd(`CMD_OP_TABLE, 3'h0, 8'h52);
    rd(ba(8'h52), 32'(pm_word(10'h306) & 14'h00FF));
    rd(ba(`IDX_TABLE_HIGH_LATCH), 32'(pm_word(10'h306) >> 8));
    cmd(`CMD_OP_DEC, 3'h0, `IDX_TBLP);
    exp_pm = 10'h305;
    cmd(`CMD_OP_TABLE, 3'h0, 8'h53);
    rd(ba(8'h53), 32'(pm_word(10'h305) & 14'h00FF));
    rd(ba(`IDX_TABLE_HIGH_LATCH), 32'(pm_word(10'h305) >> 8));
    rd({`IDX_CMD, 2'b00}, last_cmd);
    wr({`IDX_STATUS, 2'b00}, 32'h0000FFFF);
    rd({`IDX_STATUS, 2'b00}, 32'h00000000);
    wr(12'h300, 32'h00000001, 4'hF, `RESP_SLVERR);
    rd(12'h300, 32'h00000000, `RESP_SLVERR);
    print_verdict();
  end

endmodule : tb_top
